/* File: logic/core_wait_stall_unit.sv */
// stall control for the wait instructions and video pacing
`timescale 1ns/1ps
`include "core_wait_defines.svh"
module core_wait_stall_unit
  import core_wait_pkg::*;
(
  input wire logic clock_in, // system clock
  input wire logic srst_in, // sync reset
  input wire logic instr_valid_in, // instr offered
  input wire logic [31:0] instr_word_in, // instr word
  input wire logic [31:0] dest_value_in, // dest value
  input wire logic [31:0] src_value_in, // src value
  input wire logic zero_flag_in, // z flag
  input wire logic carry_flag_in, // c flag
  input wire logic [31:0] global_tick_counter_in, // tick count
  input wire logic [31:0] input_port_a_in, // port a
  input wire logic [31:0] input_port_b_in, // port b
  input wire logic single_port_variant_in, // port a only
  input wire logic counter_a_pll_tick_in, // pll pulse
  input wire logic scale_load_in, // scale load
  input wire logic [31:0] scale_value_in, // scale value
  input wire logic config_load_in, // config load
  input wire logic [31:0] config_value_in, // config value
  input wire logic video_ready_in, // word taken
  output logic instr_ready_out, // free
  output logic stall_out, // held
  output logic retire_out, // done pulse
  output logic result_write_out, // write result
  output logic [8:0] result_dest_out, // dest address
  output logic [31:0] result_value_out, // result
  output logic zero_write_out, // z write
  output logic zero_flag_out, // new z
  output logic carry_write_out, // c write
  output logic carry_flag_out, // new c
  output logic video_valid_out, // words present
  output logic [31:0] video_colour_out, // colours
  output logic [31:0] video_pixels_out, // pixels
  output logic [31:0] video_scale_out, // scale
  output logic [31:0] video_config_out, // config
  output logic [2:0] video_pin_group_out, // pin group
  output logic [7:0] video_pin_mask_out, // pin mask
  output logic video_pixel_tick_out, // pixel pulse
  output logic video_frame_tick_out // frame pulse
);

  // =====================================================================
  // state and internal signals
  core_state_s st;
  core_state_s next_st;
  logic [31:0] operand;
  logic [32:0] sum;
  logic [31:0] sampled;
  logic [31:0] masked;
  logic cond_met;
  logic accept;
  logic is_wait;
  logic [5:0] opc;
  logic [3:0] cond;
  logic buf_in_valid;
  logic buf_in_ready;
  logic buf_out_valid;
  logic [63:0] buf_out_data;
  logic [7:0] pix_last;
  logic [11:0] frame_last;

  // =====================================================================
  // operand and buffer instances
  // source operand of the offered instruction
  operand_select u_operand
  (
    .imm_in(instr_word_in[`IBIT_POS]),
    .field_in(instr_word_in[`SRC_MSB:`SRC_LSB]),
    .reg_value_in(src_value_in),
    .operand_out(operand)
  );

  // buffer so a generator stall loses no word
  pair_buffer #(
    .WIDTH(64)
  ) u_video_buf
  (
    .clock_in(clock_in),
    .srst_in(srst_in),
    .in_valid_in(buf_in_valid),
    .in_data_in({st.dval, st.oper}),
    .in_ready_out(buf_in_ready),
    .out_valid_out(buf_out_valid),
    .out_data_out(buf_out_data),
    .out_ready_in(video_ready_in)
  );

  // =====================================================================
  // decode and condition evaluation
  // fields of the offered word
  always_comb
  begin
    opc = instr_word_in[`OPC_MSB:`OPC_LSB];
    cond = instr_word_in[`COND_MSB:`COND_LSB];
    accept = instr_valid_in & st.instr_ready;
    is_wait = (opc == `OPC_PINS_EQUAL) | (opc == `OPC_PINS_DIFFER) |
              (opc == `OPC_TICK_MATCH) | (opc == `OPC_VIDEO_READY);
  end

  // target plus delta with carry
  always_comb
  begin
    sum = {1'b0, st.dval} + {1'b0, st.oper};
  end

  // port choice and mask
  always_comb
  begin
    sampled = st.sel_b ? input_port_b_in : input_port_a_in;
    masked = sampled & st.oper;
  end

  // wait condition, rechecked every clock while stalled
  always_comb
  begin
    cond_met = 1'b0;
    case (st.kind)
      KIND_TICK:
      begin
        cond_met = (global_tick_counter_in == st.dval);
      end
      KIND_PEQ:
      begin
        cond_met = (masked == st.dval) & (st.cycles >= `PIN_WAIT_MIN_CYCLES);
      end
      KIND_PNE:
      begin
        cond_met = (masked != st.dval) & (st.cycles >= `PIN_WAIT_MIN_CYCLES);
      end
      KIND_VID:
      begin
        cond_met = buf_in_ready;
      end
      default:
      begin
        cond_met = 1'b0;
      end
    endcase
  end

  // push in the cycle the wait ends
  always_comb
  begin
    buf_in_valid = (st.state == ST_WAIT) & (st.kind == KIND_VID);
  end

  // last count of each pacing divider
  always_comb
  begin
    pix_last = st.scale[`SCALE_PIX_MSB:`SCALE_PIX_LSB] - 8'h01;
    frame_last = st.scale[`SCALE_FRM_MSB:`SCALE_FRM_LSB] - 12'h001;
  end

  // =====================================================================
  // next state
  always_comb
  begin
    next_st = st;
    // pulse defaults
    next_st.retire = 1'b0;
    next_st.result_write = 1'b0;
    next_st.zero_write = 1'b0;
    next_st.carry_write = 1'b0;
    next_st.pixel_tick = 1'b0;
    next_st.frame_tick = 1'b0;
    if (srst_in)
    begin
      // reset values
      next_st = '0;
      next_st.state = ST_IDLE;
      next_st.kind = KIND_TICK;
      next_st.instr_ready = 1'b1;
      next_st.scale = `SCALE_RESET;
      next_st.config_word = `CONFIG_RESET;
      next_st.pin_group = 3'h0;
      next_st.pin_mask = 8'h00;
    end
    else
    begin
      // video registers
      if (scale_load_in)
      begin
        next_st.scale = scale_value_in;
      end
      if (config_load_in)
      begin
        next_st.config_word = config_value_in;
        next_st.pin_group = config_value_in[`CFG_GROUP_MSB:`CFG_GROUP_LSB];
        next_st.pin_mask = config_value_in[`CFG_MASK_MSB:`CFG_MASK_LSB];
      end

      // pacing on pll ticks
      if (counter_a_pll_tick_in)
      begin
        if (st.pix_count >= pix_last)
        begin
          next_st.pix_count = 8'h00;
          next_st.pixel_tick = 1'b1;
        end
        else
        begin
          next_st.pix_count = st.pix_count + 8'h01;
        end
        if (st.frame_count >= frame_last)
        begin
          next_st.frame_count = 12'h000;
          next_st.frame_tick = 1'b1;
        end
        else
        begin
          next_st.frame_count = st.frame_count + 12'h001;
        end
      end

      // instruction controller
      case (st.state)
        ST_IDLE:
        begin
          if (accept)
          begin
            // accept and latch
            next_st.instr_ready = 1'b0;
            next_st.dval = dest_value_in;
            next_st.oper = operand;
            next_st.dest_addr = instr_word_in[`DEST_MSB:`DEST_LSB];
            next_st.do_wz = instr_word_in[`ZBIT_POS];
            next_st.do_wc = instr_word_in[`CBIT_POS];
            next_st.do_wr = instr_word_in[`RBIT_POS];
            next_st.sel_b = carry_flag_in & ~single_port_variant_in;
            next_st.cycles = 3'h0;
            case (opc)
              `OPC_PINS_EQUAL:
              begin
                next_st.kind = KIND_PEQ;
              end
              `OPC_PINS_DIFFER:
              begin
                next_st.kind = KIND_PNE;
              end
              `OPC_TICK_MATCH:
              begin
                next_st.kind = KIND_TICK;
              end
              default:
              begin
                next_st.kind = KIND_VID;
              end
            endcase
            if (is_wait & (cond == `COND_ALWAYS))
            begin
              next_st.state = ST_WAIT;
              next_st.stall = 1'b1;
            end
            else
            begin
              // other opcode or condition: no effect
              next_st.state = ST_RETIRE;
              next_st.retire = 1'b1;
            end
          end
        end
        ST_WAIT:
        begin
          // count and check
          if (st.cycles != 3'h7)
          begin
            next_st.cycles = st.cycles + 3'h1;
          end
          if (cond_met)
          begin
            next_st.state = ST_RETIRE;
            next_st.stall = 1'b0;
            next_st.retire = 1'b1;
            // condition met
            next_st.result_value = sum[31:0];
            next_st.result_write = st.do_wr;
            next_st.zero_write = st.do_wz;
            if (st.kind == KIND_VID)
            begin
              next_st.zero_flag = (st.dval == st.oper);
            end
            else
            begin
              next_st.zero_flag = (sum[31:0] == 32'h0000_0000);
            end
            next_st.carry_write = st.do_wc;
            next_st.carry_flag = sum[32];
          end
        end
        // one retire cycle
        ST_RETIRE:
        begin
          next_st.state = ST_IDLE;
          next_st.instr_ready = 1'b1;
        end
        default:
        begin
          next_st.state = ST_IDLE;
          next_st.instr_ready = 1'b1;
          next_st.stall = 1'b0;
        end
      endcase
    end
  end

  // =====================================================================
  // state register
  always_ff @(posedge clock_in)
  begin
    st <= next_st;
  end

  // =====================================================================
  // outputs straight from flops
  always_comb
  begin
    instr_ready_out = st.instr_ready;
    stall_out = st.stall;
    retire_out = st.retire;
    result_write_out = st.result_write;
    result_dest_out = st.dest_addr;
    result_value_out = st.result_value;
    zero_write_out = st.zero_write;
    zero_flag_out = st.zero_flag;
    carry_write_out = st.carry_write;
    carry_flag_out = st.carry_flag;
    video_valid_out = buf_out_valid;
    video_colour_out = buf_out_data[63:32];
    video_pixels_out = buf_out_data[31:0];
    video_scale_out = st.scale;
    video_config_out = st.config_word;
    video_pin_group_out = st.pin_group;
    video_pin_mask_out = st.pin_mask;
    video_pixel_tick_out = st.pixel_tick;
    video_frame_tick_out = st.frame_tick;
  end

endmodule // core_wait_stall_unit

/* File: logic/core_wait_defines.svh */
// constants of the core wait stall unit
// =====================================================================
// What this block does
// - tick wait holds until tick counter equals target
// - on match target gains delta, then resume
// - delta is register or 9-bit immediate
// - zero-flag write: zero set when sum is zero
// - carry-flag write: carry set on 32-bit overflow
// - sum written to target unless no-result-write
// - pins-equal wait holds until masked port equals state
// - pins-differ wait holds until masked port differs
// - carry 0 port a, carry 1 port b; 32-pin always a
// - mask is register or 9-bit immediate, ANDed with port
// - pin waits take at least 5 clocks; 000i, condition 1111
// - pin waits write destination only with write-result
// - video wait holds until word buffer has room, hands words
// - colour word: four byte colours; pixels 16x2 or 32x1
// - scale sets pixel and frame counts, 160 and 2560
// - pixel rate from counter a pll ticks and scale
// - config example: pin group 001, pin mask 00001111
// - video zero-flag write: zero when colour equals pixels
// - each core owns one generator set by config
`ifndef CORE_WAIT_DEFINES_SVH
`define CORE_WAIT_DEFINES_SVH

// instruction word layout
`define OPC_MSB 31
`define OPC_LSB 26
`define ZBIT_POS 25
`define CBIT_POS 24
`define RBIT_POS 23
`define IBIT_POS 22
`define COND_MSB 21
`define COND_LSB 18
`define DEST_MSB 17
`define DEST_LSB 9
`define SRC_MSB 8
`define SRC_LSB 0

// opcodes and condition
`define OPC_PINS_EQUAL 6'h3C
`define OPC_PINS_DIFFER 6'h3D
`define OPC_TICK_MATCH 6'h3E
`define OPC_VIDEO_READY 6'h3F
`define COND_ALWAYS 4'hF

// scale and configuration fields
`define SCALE_PIX_MSB 19
`define SCALE_PIX_LSB 12
`define SCALE_FRM_MSB 11
`define SCALE_FRM_LSB 0
`define CFG_GROUP_MSB 11
`define CFG_GROUP_LSB 9
`define CFG_MASK_MSB 7
`define CFG_MASK_LSB 0
`define SCALE_EXAMPLE 32'h000A_0A00
`define CONFIG_EXAMPLE 32'h5400_020F

// reset values
`define SCALE_RESET 32'h0000_0000
`define CONFIG_RESET 32'h0000_0000

// timing counts in system clocks
`define PIN_WAIT_MIN_CYCLES 3'h3

`endif

/* File: logic/core_wait_pkg.sv */
// types for the core wait stall unit
package core_wait_pkg;

  // controller states, one-hot
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_WAIT = 3'b010,
    ST_RETIRE = 3'b100
  } wait_state_e;

  // kind of wait being held
  typedef enum logic [1:0] {
    KIND_TICK = 2'h0,
    KIND_PEQ = 2'h1,
    KIND_PNE = 2'h2,
    KIND_VID = 2'h3
  } wait_kind_e;

  typedef struct packed {
    wait_state_e state;
    wait_kind_e kind;
    logic sel_b;
    logic do_wz;
    logic do_wc;
    logic do_wr;
    logic [8:0] dest_addr;
    logic [31:0] dval;
    logic [31:0] oper;
    logic [2:0] cycles;
    logic instr_ready;
    logic stall;
    logic retire;
    logic result_write;
    logic [31:0] result_value;
    logic zero_write;
    logic zero_flag;
    logic carry_write;
    logic carry_flag;
    logic [31:0] scale;
    logic [31:0] config_word;
    logic [2:0] pin_group;
    logic [7:0] pin_mask;
    logic [7:0] pix_count;
    logic [11:0] frame_count;
    logic pixel_tick;
    logic frame_tick;
  } core_state_s;

endpackage

/* File: logic/operand_select.sv */
// source operand: register or zero-extended immediate
`timescale 1ns/1ps
module operand_select
(
  input wire logic imm_in, // immediate bit of the instruction
  input wire logic [8:0] field_in, // 9-bit source field
  input wire logic [31:0] reg_value_in, // value of the source register
  output logic [31:0] operand_out // chosen operand
);

  // immediate literal widens with zeros
  always_comb
  begin
    operand_out = imm_in ? {23'h00_0000, field_in} : reg_value_in;
  end

endmodule // operand_select

/* File: logic/pair_buffer.sv */
// two-entry valid/ready buffer
`timescale 1ns/1ps
module pair_buffer
#(
  parameter int WIDTH = 64
)
(
  input wire logic clock_in, // system clock
  input wire logic srst_in, // sync reset
  input wire logic in_valid_in, // word offered
  input wire logic [WIDTH-1:0] in_data_in, // word offered
  output logic in_ready_out, // room for a word
  output logic out_valid_out, // head word present
  output logic [WIDTH-1:0] out_data_out, // head word
  input wire logic out_ready_in // head taken
);

  typedef struct packed {
    logic [WIDTH-1:0] head;
    logic [WIDTH-1:0] tail;
    logic head_valid;
    logic tail_valid;
  } buf_state_s;

  buf_state_s st;
  buf_state_s next_st;
  logic push;
  logic pop;

  // a full buffer refuses
  always_comb
  begin
    in_ready_out = ~st.tail_valid;
    out_valid_out = st.head_valid;
    out_data_out = st.head;
    push = in_valid_in & ~st.tail_valid;
    pop = st.head_valid & out_ready_in;
  end

  // head refills from tail or from the input
  always_comb
  begin
    next_st = st;
    if (srst_in)
    begin
      next_st = '0;
    end
    else if (pop & push)
    begin
      next_st.head = in_data_in;
      next_st.head_valid = 1'b1;
    end
    else if (pop)
    begin
      next_st.head = st.tail;
      next_st.head_valid = st.tail_valid;
      next_st.tail_valid = 1'b0;
    end
    else if (push & ~st.head_valid)
    begin
      next_st.head = in_data_in;
      next_st.head_valid = 1'b1;
    end
    else if (push)
    begin
      next_st.tail = in_data_in;
      next_st.tail_valid = 1'b1;
    end
  end

  always_ff @(posedge clock_in)
  begin
    st <= next_st;
  end

endmodule // pair_buffer

/* File: tb/core_wait_props.sv */
// assertion checker for the core wait stall unit
`timescale 1ns/1ps
module core_wait_props
(
  input wire logic clock_in, // clock
  input wire logic srst_in, // reset
  input wire logic instr_valid_in, // offer
  input wire logic [31:0] instr_word_in, // word
  input wire logic [31:0] dest_value_in, // dest value
  input wire logic [31:0] src_value_in, // src value
  input wire logic carry_flag_in, // carry
  input wire logic single_port_variant_in, // port a only
  input wire logic [31:0] global_tick_counter_in, // ticks
  input wire logic [31:0] input_port_a_in, // pins a
  input wire logic [31:0] input_port_b_in, // pins b
  input wire logic video_ready_in, // taken
  input wire logic scale_load_in, // scale load
  input wire logic [31:0] scale_value_in, // scale value
  input wire logic instr_ready_out, // free
  input wire logic stall_out, // held
  input wire logic retire_out, // done
  input wire logic result_write_out, // write
  input wire logic [31:0] result_value_out, // result
  input wire logic zero_write_out, // z write
  input wire logic zero_flag_out, // z
  input wire logic carry_write_out, // c write
  input wire logic carry_flag_out, // c
  input wire logic video_valid_out, // head valid
  input wire logic [31:0] video_colour_out, // head colour
  input wire logic [31:0] video_scale_out // scale
);
  // ====================
  // latch the taken instruction, count its age
  logic [31:0] tgt;
  logic [31:0] op;
  logic [1:0] kind;
  logic is_wait;
  logic rbit;
  logic use_b;
  logic [7:0] age;
  wire take = instr_valid_in && instr_ready_out;
  wire [32:0] sum = {1'b0, tgt} + {1'b0, op};
  wire fin = retire_out && is_wait;
  wire hit = ((use_b ? input_port_b_in : input_port_a_in) & op) == tgt;
  always_ff @(posedge clock_in)
  begin
    if (take)
    begin
      tgt <= dest_value_in;
      op <= instr_word_in[22] ? {23'h00_0000, instr_word_in[8:0]} : src_value_in;
      kind <= instr_word_in[27:26];
      is_wait <= (instr_word_in[31:28] == 4'hF) && (instr_word_in[21:18] == 4'hF);
      rbit <= instr_word_in[23];
      use_b <= carry_flag_in && !single_port_variant_in;
      age <= 8'h01;
    end
    else if (age != 8'hFF)
      age <= age + 8'h01;
  end
  // ====================
  // assertions
  default clocking @(posedge clock_in); endclocking
  default disable iff (srst_in);
  stall_blocks_a: assert property (stall_out |-> !instr_ready_out)
    else $error("ready while stalled");
  tick_equal_a: assert property (fin && kind == 2'h2 |-> $past(global_tick_counter_in) == tgt)
    else $error("tick off target");
  tick_sum_a: assert property (fin && kind == 2'h2 && rbit |->
    result_write_out && result_value_out == sum[31:0])
    else $error("tick sum wrong");
  no_write_a: assert property (fin && !rbit |-> !result_write_out)
    else $error("unasked write");
  tick_zero_a: assert property (fin && kind == 2'h2 && zero_write_out |->
    zero_flag_out == (sum[31:0] == 32'h0000_0000))
    else $error("tick zero wrong");
  tick_carry_a: assert property (fin && kind == 2'h2 && carry_write_out |->
    carry_flag_out == sum[32])
    else $error("tick carry wrong");
  pin_equal_a: assert property (fin && kind == 2'h0 |-> $past(hit) && age >= 8'h05)
    else $error("pins equal early");
  pin_differ_a: assert property (fin && kind == 2'h1 |-> !$past(hit) && age >= 8'h05)
    else $error("pins differ early");
  video_zero_a: assert property (fin && kind == 2'h3 && zero_write_out |->
    zero_flag_out == (tgt == op))
    else $error("video zero wrong");
  video_hold_a: assert property (video_valid_out && !video_ready_in |=>
    video_valid_out && $stable(video_colour_out))
    else $error("video word dropped");
  scale_load_a: assert property (scale_load_in |=> video_scale_out == $past(scale_value_in))
    else $error("scale not loaded");
  // main scenarios
  cover property (fin && kind == 2'h2);
  cover property (fin && kind == 2'h1);
  cover property (video_valid_out && !video_ready_in ##1 video_valid_out);
endmodule // core_wait_props

/* File: tb/far_side_model.sv */
// far side: generator, tick counter, pll
`timescale 1ns/1ps
module far_side_model
(
  input wire logic clock_in, // clock
  input wire logic srst_in, // reset
  input wire logic hold_in, // generator not started
  input wire logic fast_in, // take every cycle
  input wire logic load_in, // set tick counter
  input wire logic [31:0] load_value_in, // counter value
  input wire logic video_valid_in, // words offered
  input wire logic [31:0] colour_in, // colour word
  input wire logic [31:0] pixels_in, // pixel word
  output logic video_ready_out, // word taken
  output logic [31:0] tick_out, // global tick counter
  output logic pll_out, // pll pulse
  output logic [7:0] taken_out, // words taken
  output logic [31:0] last_colour_out, // last colour
  output logic [31:0] last_pixels_out // last pixels
);
  logic phase;
  // idle until started; slow: every other cycle
  assign video_ready_out = !hold_in && (fast_in || phase);
  assign pll_out = phase;
  // counter, pll and taken words
  always_ff @(posedge clock_in)
  begin
    phase <= srst_in ? 1'b0 : !phase;
    tick_out <= load_in ? load_value_in : tick_out + 32'h0000_0001;
    if (srst_in)
      taken_out <= 8'h00;
    else if (video_valid_in && video_ready_out)
    begin
      taken_out <= taken_out + 8'h01;
      last_colour_out <= colour_in;
      last_pixels_out <= pixels_in;
    end
  end
endmodule // far_side_model

/* File: tb/core_wait_stall_unit_bench.sv */
// self-checking bench for the core wait stall unit
`timescale 1ns/1ps
`include "core_wait_defines.svh"
module core_wait_stall_unit_bench;
  logic clock_in, srst_in, instr_valid_in, carry_flag_in, single_port_variant_in;
  logic scale_load_in, config_load_in, hold, fast, cnt_load;
  logic [31:0] instr_word_in, dest_value_in, src_value_in, input_port_a_in, input_port_b_in;
  logic [31:0] scale_value_in, config_value_in, cnt_value, pa_nx, pb_nx;
  wire instr_ready_out, stall_out, retire_out, result_write_out, zero_write_out, zero_flag_out;
  wire carry_write_out, carry_flag_out, video_valid_out, video_pixel_tick_out;
  wire video_frame_tick_out, pll, vrdy;
  wire [8:0] result_dest_out;
  wire [2:0] video_pin_group_out;
  wire [7:0] video_pin_mask_out, taken;
  wire [31:0] result_value_out, video_colour_out, video_pixels_out, video_scale_out;
  wire [31:0] video_config_out, tick, lastc, lastp;
  int err_total = 0;
  int cmp_count = 0;
  int n;
  core_wait_stall_unit i_core_wait_stall_unit (.*, .zero_flag_in(1'b0),
    .global_tick_counter_in(tick), .counter_a_pll_tick_in(pll), .video_ready_in(vrdy));
  far_side_model i_far_side_model (.clock_in, .srst_in, .hold_in(hold), .fast_in(fast),
    .load_in(cnt_load), .load_value_in(cnt_value), .video_valid_in(video_valid_out),
    .colour_in(video_colour_out), .pixels_in(video_pixels_out), .video_ready_out(vrdy),
    .tick_out(tick), .pll_out(pll), .taken_out(taken), .last_colour_out(lastc),
    .last_pixels_out(lastp));
  initial
  begin
    clock_in = 1'b0;
    forever #20 clock_in = ~clock_in;
  end
  // ====================
  // checking and closing
  task wrap_up();
    $display("checks %0d errors %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      err_total++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task lim(input int k, input int b);
    if (k >= b)
    begin
      err_total++;
      $display("Error wait limit expected below %0d seen %0d", b, k);
      wrap_up();
    end
  endtask
  // ====================
  // access tasks
  function automatic logic [31:0] iw(logic [5:0] o, logic [3:0] f, logic [3:0] cd,
    logic [8:0] s);
    return {o, f, cd, 9'h000, s};
  endfunction
  // offer, wait for retire; at cycle rel release far side
  task automatic run(input logic [31:0] w, d, s, input logic c, input int rel, output int k);
    @(negedge clock_in);
    chk("ready", instr_ready_out, 32'h1);
    instr_valid_in = 1'b1;
    instr_word_in = w;
    dest_value_in = d;
    src_value_in = s;
    carry_flag_in = c;
    @(negedge clock_in);
    instr_valid_in = 1'b0;
    k = 1;
    while (retire_out !== 1'b1 && k < 300)
    begin
      if (k == rel)
      begin
        chk("stall", stall_out, 32'h1);
        hold = 1'b0;
        input_port_a_in = pa_nx;
        input_port_b_in = pb_nx;
      end
      @(negedge clock_in);
      k++;
    end
    lim(k, 300);
  endtask
  task setcnt(input logic [31:0] v);
    @(negedge clock_in);
    cnt_load = 1'b1;
    cnt_value = v;
    @(negedge clock_in);
    cnt_load = 1'b0;
  endtask
  task automatic pin(input logic [5:0] o, input logic [31:0] pa0, pb0, pa1, pb1,
    input logic c, v, input int ex);
    int k;
    input_port_a_in = pa0;
    input_port_b_in = pb0;
    pa_nx = pa1;
    pb_nx = pb1;
    single_port_variant_in = v;
    run(iw(o, 4'h1, 4'hF, 9'h0FF), 32'h0000_005A, 32'h0000_0000, c, 10, k);
    if (ex > 0)
      chk("pin cycles", k, ex);
    chk("pin write", result_write_out, 32'h0);
  endtask
  task automatic gap(input logic fr, output int k);
    int j;
    j = 0;
    while ((fr ? video_frame_tick_out : video_pixel_tick_out) !== 1'b1 && j < 6000)
    begin
      @(negedge clock_in);
      j++;
    end
    k = 0;
    do
    begin
      @(negedge clock_in);
      k++;
    end
    while ((fr ? video_frame_tick_out : video_pixel_tick_out) !== 1'b1 && k < 6000);
    lim(k + j / 6000 * 6000, 6000);
  endtask
  // ====================
  // main sequence
  initial
  begin
    {instr_valid_in, carry_flag_in, single_port_variant_in, scale_load_in} = 4'h0;
    {config_load_in, cnt_load, hold, fast, srst_in} = 5'h07;
    {instr_word_in, dest_value_in, src_value_in, scale_value_in} = 128'h0;
    {input_port_a_in, input_port_b_in, config_value_in, cnt_value} = 128'h0;
    {pa_nx, pb_nx} = 64'h0;
    repeat (12) @(negedge clock_in);
    srst_in = 1'b0;
    chk("scale rst", video_scale_out, 32'h0000_0000);
    chk("config rst", video_config_out, 32'h0000_0000);
    chk("video rst", video_valid_out, 32'h0);
    run(iw(6'h00, 4'hE, 4'hF, 9'h001), 32'h0, 32'h0, 1'b0, 0, n);
    chk("plain cycles", n, 32'h1);
    chk("plain write", result_write_out, 32'h0);
    run(iw(`OPC_TICK_MATCH, 4'hE, 4'h0, 9'h001), 32'h0, 32'h0, 1'b0, 0, n);
    chk("cond cycles", n, 32'h1);
    setcnt(32'hFFFF_FFF0);
    run(iw(`OPC_TICK_MATCH, 4'hF, 4'hF, 9'h001), 32'hFFFF_FFFF, 32'h0, 1'b0, 0, n);
    chk("tick waited", n > 12, 32'h1);
    chk("tick sum", result_value_out, 32'h0000_0000);
    chk("tick z", {zero_write_out, zero_flag_out}, 32'h3);
    chk("tick c", {carry_write_out, carry_flag_out}, 32'h3);
    setcnt(32'h0000_0000);
    run(iw(`OPC_TICK_MATCH, 4'hC, 4'hF, 9'h000), 32'h0000_0020, 32'h1234_5678, 1'b0, 0, n);
    chk("tick nr", result_write_out, 32'h0);
    chk("tick z0", {zero_write_out, zero_flag_out}, 32'h2);
    chk("tick c0", {carry_write_out, carry_flag_out}, 32'h2);
    setcnt(32'h0000_0000);
    run(iw(`OPC_TICK_MATCH, 4'h3, 4'hF, 9'h1FF), 32'h0000_0040, 32'h0, 1'b0, 0, n);
    chk("tick imm", result_value_out, 32'h0000_023F);
    chk("tick nz", zero_write_out, 32'h0);
    pin(`OPC_PINS_EQUAL, 0, 0, 32'h1234_565A, 0, 1'b0, 1'b0, 11);
    pin(`OPC_PINS_EQUAL, 0, 0, 0, 32'h0000_FF5A, 1'b1, 1'b0, 11);
    pin(`OPC_PINS_EQUAL, 0, 32'h5A, 32'h5A, 32'h5A, 1'b1, 1'b1, 11);
    pin(`OPC_PINS_DIFFER, 32'h5A, 0, 32'h5B, 0, 1'b0, 1'b0, 11);
    pin(`OPC_PINS_EQUAL, 32'h5A, 0, 32'h5A, 0, 1'b0, 1'b0, 5);
    hold = 1'b1;
    run(iw(`OPC_VIDEO_READY, 4'h9, 4'hF, 9'h055), 32'h0000_0055, 32'h0, 1'b0, 0, n);
    chk("vid1 cycles", n, 32'h2);
    chk("vid1 z", {zero_write_out, zero_flag_out}, 32'h3);
    run(iw(`OPC_VIDEO_READY, 4'h8, 4'hF, 9'h000), 32'h1122_3344, 32'hAABB_CCDD, 1'b0, 0, n);
    chk("vid2 z", {zero_write_out, zero_flag_out}, 32'h2);
    run(iw(`OPC_VIDEO_READY, 4'h0, 4'hF, 9'h000), 32'hCAFE_0001, 32'h8000_0001, 1'b0, 10, n);
    chk("vid3 stalled", n > 10, 32'h1);
    repeat (6) @(negedge clock_in);
    chk("taken", taken, 32'h3);
    chk("colour", lastc, 32'hCAFE_0001);
    chk("pixels", lastp, 32'h8000_0001);
    fast = 1'b0;
    run(iw(`OPC_VIDEO_READY, 4'h1, 4'hF, 9'h1A5), 32'h0102_0304, 32'h0, 1'b0, 0, n);
    repeat (8) @(negedge clock_in);
    chk("slow taken", taken, 32'h4);
    chk("imm pixels", lastp, 32'h0000_01A5);
    chk("drained", video_valid_out, 32'h0);
    scale_value_in = `SCALE_EXAMPLE;
    config_value_in = `CONFIG_EXAMPLE;
    {scale_load_in, config_load_in} = 2'h3;
    @(negedge clock_in);
    {scale_load_in, config_load_in} = 2'h0;
    chk("scale", video_scale_out, 32'h000A_0A00);
    chk("group", video_pin_group_out, 32'h1);
    chk("mask", video_pin_mask_out, 32'h0F);
    gap(1'b0, n);
    chk("pixel period", n, 32'd320);
    gap(1'b1, n);
    chk("frame period", n, 32'd5120);
    wrap_up();
  end
endmodule // core_wait_stall_unit_bench

bind core_wait_stall_unit core_wait_props i_core_wait_props (.*);
